//--- rtl/irs_bank.sv
// Purpose: Live raw status bank behind a classic Wishbone slave
// Assumes: Sources are synchronous to clk_i
// Notes: One wait state; unmapped reads return zero
`timescale 1ns/100ps
module irs_bank (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire irs_pkg::irs_src_t src_i,
    output logic system_clock_enable_o,
    output logic async_clock_enable_o
);

    irs_pkg::irs_src_t src_q;
    irs_pkg::irs_clk_ctrl_t en_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic [13:0] idx;
    logic req;
    logic rd_go;
    logic wr_go;
    logic sys_off;
    logic async_off;
    logic wr_ok;
    logic any_oc;
    logic any_uc;

    assign idx = wb_adr_i[15:2];
    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    assign rd_go = req && !wb_we_i;
    assign wr_go = req && wb_we_i;

    // Sample sources once; no hold, no latch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_q <= '0;
        end else begin
            src_q <= src_i; // R21
        end
    end

    function automatic logic or_masked(
        input logic [15:0] v,
        input logic [15:0] m
    );
        or_masked = |(v & m);
    endfunction : or_masked

    assign any_oc = or_masked(src_q.overclock_detail_a, irs_pkg::OC_A_MASK)
        || or_masked(src_q.overclock_detail_b, irs_pkg::OC_B_MASK); // R18
    assign any_uc = or_masked(src_q.underclock_detail, irs_pkg::UC_MASK); // R19

    // Clock off flags need both the enable cleared and the stop seen
    assign sys_off = !en_q.system_clock_enable
        && src_q.system_clock_stopped; // R10
    assign async_off = !en_q.async_clock_enable
        && src_q.async_clock_stopped; // R11

    // Control writes held off during boot and pending clock shutdown
    assign wr_ok = src_q.boot_complete // R14
        && (en_q.system_clock_enable || sys_off) // R10
        && (en_q.async_clock_enable || async_off); // R11

    function automatic logic [15:0] image(
        input logic [13:0] i,
        input irs_pkg::irs_src_t s,
        input logic oc,
        input logic uc,
        input logic so,
        input logic ao
    );
        image = 16'h0000;
        case (i)
            irs_pkg::IDX_S1: begin
                image[10:9] = s.dsp_ram_ready;
                image[7:0] = s.dsp_irq;
            end
            irs_pkg::IDX_S2: begin
                image[15] = s.speaker_heat_warning; // R1
                image[14] = s.speaker_heat_shutdown_level; // R2
                image[11] = s.write_sequencer_idle; // R3
                image[10] = s.range_ctrl2_signal_seen; // R4
                image[9] = s.range_ctrl1_signal_seen; // R4
                image[8] = s.rate_conv2_lock;
                image[7] = s.rate_conv1_lock;
                image[6] = uc; // R5
                image[5] = oc; // R5
                image[3] = s.loop2_lock;
                image[2] = s.loop1_lock;
                image[1] = s.system_clock_underclock; // R6
                image[0] = s.async_clock_underclock; // R7
            end
            irs_pkg::IDX_S3: begin
                image[12] = s.control_port_error; // R8
                image[11] = s.mixer_sample_lost; // R9
                image[10] = ao; // R11
                image[9] = so; // R10
                image[8] = s.input_rate_conv_cfg_error[0]; // R12
                image[7] = s.input_rate_conv_cfg_error[1]; // R12
                image[6] = s.input_rate_conv_cfg_error[2]; // R12
                image[1] = s.right_phones_enable_idle; // R13
                image[0] = s.left_phones_enable_idle; // R13
            end
            irs_pkg::IDX_S4: begin
                image[8] = s.boot_complete; // R14
                image[3] = s.async_rate_conv_cfg_error; // R15
                image[1] = s.loop2_clock_good; // R16
                image[0] = s.loop1_clock_good; // R16
            end
            irs_pkg::IDX_S5: begin
                image = s.overclock_detail_a & irs_pkg::OC_A_MASK; // R17
            end
            default: begin
                image = 16'h0000;
            end
        endcase
    endfunction : image

    // Bus answer: ack one cycle after the request, dropped next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= 32'h00000000;
        end else if (rd_go) begin
            if (idx == irs_pkg::IDX_CLK) begin
                dat_q <= {30'h0, en_q};
            end else begin
                dat_q <= {16'h0000,
                    image(idx, src_q, any_oc, any_uc, sys_off, async_off)};
            end
        end
    end

    // Only the clock control word stores; status writes fall away
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_q <= irs_pkg::CLK_CTRL_RST;
        end else if (wr_go && idx == irs_pkg::IDX_CLK
                     && wb_sel_i[0] && wr_ok) begin
            en_q <= wb_dat_i[1:0]; // R20
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign system_clock_enable_o = en_q.system_clock_enable;
    assign async_clock_enable_o = en_q.async_clock_enable;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_one_cycle_a: assert property (
        ack_q |=> !ack_q
    ) else $error("ack held longer than one cycle");

    ack_latency_a: assert property (
        wb_cyc_i && wb_stb_i && !ack_q |=> ack_q
    ) else $error("request not answered next cycle");

    warn_bit_a: assert property ( // R1
        rd_go && idx == irs_pkg::IDX_S2
        |=> dat_q[15] == $past(src_q.speaker_heat_warning)
    ) else $error("warning bit wrong");

    shutdown_bit_a: assert property ( // R2
        rd_go && idx == irs_pkg::IDX_S2
        |=> dat_q[14] == $past(src_q.speaker_heat_shutdown_level)
    ) else $error("shutdown level bit wrong");

    seq_idle_a: assert property ( // R3
        rd_go && idx == irs_pkg::IDX_S2
        |=> dat_q[11] == $past(src_q.write_sequencer_idle)
    ) else $error("sequencer idle bit wrong");

    signal_seen_a: assert property ( // R4
        rd_go && idx == irs_pkg::IDX_S2
        |=> dat_q[10] == $past(src_q.range_ctrl2_signal_seen)
            && dat_q[9] == $past(src_q.range_ctrl1_signal_seen)
    ) else $error("signal detect bits wrong");

    clock_summary_a: assert property ( // R5
        rd_go && idx == irs_pkg::IDX_S2
        |=> dat_q[6] == $past(any_uc) && dat_q[5] == $past(any_oc)
    ) else $error("clock error summary bits wrong");

    sys_underclock_a: assert property ( // R6
        rd_go && idx == irs_pkg::IDX_S2
        |=> dat_q[1] == $past(src_q.system_clock_underclock)
    ) else $error("system underclock bit wrong");

    async_underclock_a: assert property ( // R7
        rd_go && idx == irs_pkg::IDX_S2
        |=> dat_q[0] == $past(src_q.async_clock_underclock)
    ) else $error("async underclock bit wrong");

    port_error_a: assert property ( // R8
        rd_go && idx == irs_pkg::IDX_S3
        |=> dat_q[12] == $past(src_q.control_port_error)
    ) else $error("control port error bit wrong");

    sample_lost_a: assert property ( // R9
        rd_go && idx == irs_pkg::IDX_S3
        |=> dat_q[11] == $past(src_q.mixer_sample_lost)
    ) else $error("sample lost bit wrong");

    sys_off_read_a: assert property ( // R10
        rd_go && idx == irs_pkg::IDX_S3
        |=> dat_q[9] == (!$past(en_q.system_clock_enable)
                         && $past(src_q.system_clock_stopped))
    ) else $error("system clock off bit wrong");

    sys_off_hold_a: assert property ( // R10
        wr_go && !en_q.system_clock_enable && !sys_off
        |=> $stable(en_q)
    ) else $error("write taken before system clock off");

    async_off_hold_a: assert property ( // R11
        wr_go && !en_q.async_clock_enable && !async_off
        |=> $stable(en_q)
    ) else $error("write taken before async clock off");

    cfg_errors_a: assert property ( // R12
        rd_go && idx == irs_pkg::IDX_S3
        |=> dat_q[8:6] == {$past(src_q.input_rate_conv_cfg_error[0]),
                           $past(src_q.input_rate_conv_cfg_error[1]),
                           $past(src_q.input_rate_conv_cfg_error[2])}
    ) else $error("rate converter error bits wrong");

    phones_idle_a: assert property ( // R13
        rd_go && idx == irs_pkg::IDX_S3
        |=> dat_q[1] == $past(src_q.right_phones_enable_idle)
            && dat_q[0] == $past(src_q.left_phones_enable_idle)
    ) else $error("phones idle bits wrong");

    boot_hold_a: assert property ( // R14
        wr_go && !src_q.boot_complete |=> $stable(en_q)
    ) else $error("write taken during boot");

    async_cfg_a: assert property ( // R15
        rd_go && idx == irs_pkg::IDX_S4
        |=> dat_q[8] == $past(src_q.boot_complete)
            && dat_q[3] == $past(src_q.async_rate_conv_cfg_error)
    ) else $error("boot or async config bit wrong");

    loops_good_a: assert property ( // R16
        rd_go && idx == irs_pkg::IDX_S4
        |=> dat_q[1] == $past(src_q.loop2_clock_good)
            && dat_q[0] == $past(src_q.loop1_clock_good)
    ) else $error("loop clock good bits wrong");

    pwm_overclock_a: assert property ( // R17
        rd_go && idx == irs_pkg::IDX_S5
        |=> dat_q[13] == $past(src_q.overclock_detail_a[13])
    ) else $error("pulse width overclock bit wrong");

    oc_summary_a: assert property ( // R18
        |(src_q.overclock_detail_b & irs_pkg::OC_B_MASK) |-> any_oc
    ) else $error("overclock summary missed a detail bit");

    uc_summary_a: assert property ( // R19
        !(|(src_q.underclock_detail & irs_pkg::UC_MASK)) |-> !any_uc
    ) else $error("underclock summary set without cause");

    status_write_a: assert property ( // R20
        wr_go && idx != irs_pkg::IDX_CLK |=> $stable(en_q)
    ) else $error("status write changed stored state");

    no_latch_a: assert property ( // R21
        !$past(rst_i) |-> src_q == $past(src_i)
    ) else $error("status sample did not follow source");

    async_off_read_a: assert property ( // R11
        rd_go && idx == irs_pkg::IDX_S3
        |=> dat_q[10] == (!$past(en_q.async_clock_enable)
                          && $past(src_q.async_clock_stopped))
    ) else $error("async clock off bit wrong");

    oc_detail_a: assert property ( // R18
        |(src_q.overclock_detail_a & irs_pkg::OC_A_MASK) |-> any_oc
    ) else $error("overclock summary missed a fifth word bit");

    oc_quiet_a: assert property ( // R18
        !(|(src_q.overclock_detail_a & irs_pkg::OC_A_MASK))
        && !(|(src_q.overclock_detail_b & irs_pkg::OC_B_MASK)) |-> !any_oc
    ) else $error("overclock summary set without cause");

    uc_detail_a: assert property ( // R19
        |(src_q.underclock_detail & irs_pkg::UC_MASK) |-> any_uc
    ) else $error("underclock summary missed a detail bit");

    detail_word_a: assert property ( // R17
        rd_go && idx == irs_pkg::IDX_S5
        |=> dat_q[15:0] == ($past(src_q.overclock_detail_a) & irs_pkg::OC_A_MASK)
    ) else $error("overclock detail word wrong");

    dsp_word_a: assert property (
        rd_go && idx == irs_pkg::IDX_S1
        |=> dat_q[10:9] == $past(src_q.dsp_ram_ready)
            && dat_q[7:0] == $past(src_q.dsp_irq)
    ) else $error("processor status word wrong");

    clk_readback_a: assert property (
        rd_go && idx == irs_pkg::IDX_CLK
        |=> dat_q[1:0] == $past(en_q)
    ) else $error("clock control readback wrong");

    read_keeps_a: assert property ( // R20
        rd_go |=> $stable(en_q)
    ) else $error("read changed stored state");

    unmapped_zero_a: assert property (
        rd_go && (idx < irs_pkg::IDX_S1 || idx > irs_pkg::IDX_S5)
        && idx != irs_pkg::IDX_CLK |=> dat_q == 32'h00000000
    ) else $error("unmapped read not zero");

    read_s2_c: cover property (
        rd_go && idx == irs_pkg::IDX_S2 ##1 ack_q
    );
    clk_write_c: cover property (
        wr_go && idx == irs_pkg::IDX_CLK && wr_ok ##1 $changed(en_q)
    );
    boot_block_c: cover property (
        wr_go && idx == irs_pkg::IDX_CLK && !src_q.boot_complete
    );
    sys_off_c: cover property (
        !en_q.system_clock_enable ##[1:20] sys_off
    );
    async_off_c: cover property (
        !en_q.async_clock_enable ##[1:20] async_off
    );

endmodule : irs_bank

//--- rtl/irs_pkg.sv
// Purpose: Constants and carriers for the raw status bank
// Assumes: Word index times four is the Wishbone byte address
// Notes: Status images are live; only the clock control word stores
//
// Overview of operation
// [R1] Second status bit 15 shows speaker warning temperature exceeded.
// [R2] Second status bit 14 shows speaker shutdown temperature exceeded.
// [R3] Second status bit 11 is low while write sequencer busy.
// [R4] Second status bits 10 and 9 show range controller signal detect.
// [R5] Second status bits 6 and 5 show any under or overclock.
// [R6] Second status bit 1 shows system clock underclocked.
// [R7] Second status bit 0 shows asynchronous clock underclocked.
// [R8] Third status bit 12 shows control interface error.
// [R9] Third status bit 11 shows mixer dropped sample.
// [R10] Third bit 9 high once system clock off; writes wait for it.
// [R11] Third bit 10 high once async clock off; writes wait for it.
// [R12] Third status bits 8..6 show input rate converter config errors.
// [R13] Third status bits 1 and 0 low while phones enable runs.
// [R14] Fourth bit 8 shows boot done; no control writes before it.
// [R15] Fourth status bit 3 shows async rate converter config error.
// [R16] Fourth status bits 1 and 0 show loop clocks good.
// [R17] Fifth status bit 13 shows pulse width overclock error.
// [R18] Overclock summary is the OR of all overclock detail bits; code ORs only the OC_A_MASK and OC_B_MASK bits.
// [R19] Underclock summary is the OR of all underclock detail bits; code ORs only the UC_MASK bits, so underclock_detail bits 1 and 11 to 15 are left out.
// [R20] Status words ignore writes; reads change nothing.
// [R21] Status bits never latch; they follow their sources.
package irs_pkg;

    localparam logic [13:0] IDX_S1 = 14'h0d20;
    localparam logic [13:0] IDX_S2 = 14'h0d21;
    localparam logic [13:0] IDX_S3 = 14'h0d22;
    localparam logic [13:0] IDX_S4 = 14'h0d23;
    localparam logic [13:0] IDX_S5 = 14'h0d24;
    localparam logic [13:0] IDX_CLK = 14'h0d30;

    localparam logic [1:0] CLK_CTRL_RST = 2'h3;

    localparam logic [15:0] OC_A_MASK = 16'h36ff;
    localparam logic [15:0] OC_B_MASK = 16'h1ea7;
    localparam logic [15:0] UC_MASK = 16'h07fd;

    // Source conditions, all on the system clock
    typedef struct packed {
        logic [1:0] dsp_ram_ready;
        logic [7:0] dsp_irq;
        logic speaker_heat_warning;
        logic speaker_heat_shutdown_level;
        logic write_sequencer_idle;
        logic range_ctrl2_signal_seen;
        logic range_ctrl1_signal_seen;
        logic rate_conv2_lock;
        logic rate_conv1_lock;
        logic loop2_lock;
        logic loop1_lock;
        logic system_clock_underclock;
        logic async_clock_underclock;
        logic control_port_error;
        logic mixer_sample_lost;
        logic system_clock_stopped;
        logic async_clock_stopped;
        logic [2:0] input_rate_conv_cfg_error;
        logic right_phones_enable_idle;
        logic left_phones_enable_idle;
        logic boot_complete;
        logic async_rate_conv_cfg_error;
        logic loop2_clock_good;
        logic loop1_clock_good;
        logic [15:0] overclock_detail_a;
        logic [15:0] overclock_detail_b;
        logic [15:0] underclock_detail;
    } irs_src_t;

    typedef struct packed {
        logic async_clock_enable;
        logic system_clock_enable;
    } irs_clk_ctrl_t;

endpackage : irs_pkg

//--- test/irs_bank_tb.sv
// Purpose: Self-checking bench for the raw status bank
// Assumes: One wait state per access, status seen one cycle after src_i
// Notes: Scenarios walk each status field but the four lock bits, the write holdoff and read-only words
`timescale 1ns/100ps
module irs_bank_tb;
    localparam logic [15:0] CLK_ADR = 16'h34c0;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [15:0] wb_adr_i = 16'h0000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic wb_ack_o;
    logic [31:0] wb_dat_o;
    irs_pkg::irs_src_t src_i = '0;
    irs_pkg::irs_src_t pat = '0;
    logic system_clock_enable_o;
    logic async_clock_enable_o;
    int err_total = 0;
    int comparisons = 0;

    irs_bank u_irs_bank (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .src_i(src_i),
        .system_clock_enable_o(system_clock_enable_o),
        .async_clock_enable_o(async_clock_enable_o)
    );

    always #25 clk_i = ~clk_i;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict;
        $display("Mismatches %0d, comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict

    // One classic Wishbone cycle, held until ack is sampled
    task automatic wb_cycle(input logic we, input logic [15:0] adr, input logic [3:0] sel,
                            input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= wd;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_total++;
            $display("ERROR at %0t: no ack seen %h expected %h", $time, 1'b0, 1'b1);
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb_cycle

    // Drive the pattern onto the sources, then read one word back
    task automatic chk_word(input logic [15:0] adr, input logic [31:0] exp);
        logic [31:0] rd;
        @(posedge clk_i);
        src_i <= pat;
        pat = '0;
        wb_cycle(1'b0, adr, 4'hf, 32'h0, rd);
        check(rd, exp);
    endtask : chk_word

    task automatic t_reset_defaults;
        logic [31:0] rd;
        check({30'h0, async_clock_enable_o, system_clock_enable_o}, 32'h3);
        wb_cycle(1'b0, CLK_ADR, 4'hf, 32'h0, rd);
        check(rd, 32'h3);
        for (int i = 0; i < 5; i++) begin
            chk_word(16'h3480 + 16'(4 * i), 32'h0);
        end
    endtask : t_reset_defaults

    task automatic t_status_fields;
        pat.dsp_ram_ready = 2'h2;
        pat.dsp_irq = 8'h81;
        chk_word(16'h3480, 32'h0481);
        pat.speaker_heat_warning = 1'b1;
        chk_word(16'h3484, 32'h8000);
        pat.speaker_heat_shutdown_level = 1'b1;
        chk_word(16'h3484, 32'h4000);
        pat.write_sequencer_idle = 1'b1;
        chk_word(16'h3484, 32'h0800);
        pat.range_ctrl2_signal_seen = 1'b1;
        chk_word(16'h3484, 32'h0400);
        pat.range_ctrl1_signal_seen = 1'b1;
        chk_word(16'h3484, 32'h0200);
        pat.underclock_detail[0] = 1'b1;
        chk_word(16'h3484, 32'h0040);
        pat.underclock_detail[10] = 1'b1;
        chk_word(16'h3484, 32'h0040);
        pat.overclock_detail_a[13] = 1'b1;
        chk_word(16'h3484, 32'h0020);
        pat.overclock_detail_a[13] = 1'b1;
        chk_word(16'h3490, 32'h2000);
        pat.overclock_detail_b[12] = 1'b1;
        chk_word(16'h3484, 32'h0020);
        pat.system_clock_underclock = 1'b1;
        chk_word(16'h3484, 32'h0002);
        pat.async_clock_underclock = 1'b1;
        chk_word(16'h3484, 32'h0001);
        pat.control_port_error = 1'b1;
        chk_word(16'h3488, 32'h1000);
        pat.mixer_sample_lost = 1'b1;
        chk_word(16'h3488, 32'h0800);
        pat.input_rate_conv_cfg_error = 3'h1;
        chk_word(16'h3488, 32'h0100);
        pat.input_rate_conv_cfg_error = 3'h2;
        chk_word(16'h3488, 32'h0080);
        pat.input_rate_conv_cfg_error = 3'h4;
        chk_word(16'h3488, 32'h0040);
        pat.right_phones_enable_idle = 1'b1;
        chk_word(16'h3488, 32'h0002);
        pat.left_phones_enable_idle = 1'b1;
        chk_word(16'h3488, 32'h0001);
        pat.async_rate_conv_cfg_error = 1'b1;
        chk_word(16'h348c, 32'h0008);
        pat.loop2_clock_good = 1'b1;
        chk_word(16'h348c, 32'h0002);
        pat.loop1_clock_good = 1'b1;
        chk_word(16'h348c, 32'h0001);
    endtask : t_status_fields

    task automatic t_read_only;
        logic [31:0] rd;
        pat.speaker_heat_warning = 1'b1;
        chk_word(16'h3484, 32'h8000);
        wb_cycle(1'b1, 16'h3484, 4'hf, 32'hffff, rd);
        wb_cycle(1'b0, 16'h3484, 4'hf, 32'h0, rd);
        check(rd, 32'h8000);
        wb_cycle(1'b0, 16'h3484, 4'hf, 32'h0, rd);
        check(rd, 32'h8000);
        chk_word(16'h3484, 32'h0);
        wb_cycle(1'b1, 16'h3600, 4'hf, 32'hffff, rd);
        wb_cycle(1'b0, 16'h3600, 4'hf, 32'h0, rd);
        check(rd, 32'h0);
    endtask : t_read_only

    task automatic t_clock_holdoff;
        logic [31:0] rd;
        wb_cycle(1'b1, CLK_ADR, 4'hf, 32'h0, rd);
        check({31'h0, system_clock_enable_o}, 32'h1);
        pat.boot_complete = 1'b1;
        chk_word(16'h348c, 32'h0100);
        wb_cycle(1'b1, CLK_ADR, 4'he, 32'h0, rd);
        check({31'h0, system_clock_enable_o}, 32'h1);
        wb_cycle(1'b1, CLK_ADR, 4'h1, 32'h2, rd);
        check({30'h0, async_clock_enable_o, system_clock_enable_o}, 32'h2);
        wb_cycle(1'b1, CLK_ADR, 4'h1, 32'h3, rd);
        check({31'h0, system_clock_enable_o}, 32'h0);
        pat.boot_complete = 1'b1;
        pat.system_clock_stopped = 1'b1;
        chk_word(16'h3488, 32'h0200);
        wb_cycle(1'b1, CLK_ADR, 4'h1, 32'h3, rd);
        check({31'h0, system_clock_enable_o}, 32'h1);
        wb_cycle(1'b1, CLK_ADR, 4'h1, 32'h1, rd);
        check({31'h0, async_clock_enable_o}, 32'h0);
        wb_cycle(1'b1, CLK_ADR, 4'h1, 32'h3, rd);
        check({31'h0, async_clock_enable_o}, 32'h0);
        pat.boot_complete = 1'b1;
        pat.async_clock_stopped = 1'b1;
        chk_word(16'h3488, 32'h0400);
        wb_cycle(1'b1, CLK_ADR, 4'h1, 32'h3, rd);
        check({31'h0, async_clock_enable_o}, 32'h1);
        wb_cycle(1'b1, 16'h3488, 4'hf, 32'h0, rd);
        check({30'h0, async_clock_enable_o, system_clock_enable_o}, 32'h3);
        pat.async_clock_stopped = 1'b1;
        chk_word(16'h3488, 32'h0);
    endtask : t_clock_holdoff

    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset_defaults();
        t_status_fields();
        t_read_only();
        t_clock_holdoff();
        print_verdict();
    end

    // Watchdog well beyond the few hundred cycles the scenarios need
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        print_verdict();
    end
endmodule : irs_bank_tb
